// ==== core/wiper_i2c_pkg.sv ====
package wiper_i2c_pkg;

  // Two fixed device addresses, no strap pins
  localparam logic [6:0] ADDR_OPTION_LOW = 7'h2E;
  localparam logic [6:0] ADDR_OPTION_HIGH = 7'h3E;
  localparam logic [7:0] CMD_SETTING = 8'h00;

  localparam int SETTING_W = 7;
  localparam logic [6:0] SETTING_RESET = 7'h20;
  localparam logic [6:0] WIPER_FULL = 7'h40;
  localparam logic [6:0] WIPER_LIMIT = 7'h3F;

  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int BUF_DEPTH = 2;

  typedef enum logic [6:0]
  {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_CMD = 7'h04,
    ST_WDATA = 7'h08,
    ST_RDATA = 7'h10,
    ST_RDONE = 7'h20,
    ST_IGNORE = 7'h40
  } slave_state_e;

endpackage

// ==== core/wiper_pair_buffer.sv ====
`timescale 1ns/1ps
`default_nettype none

module wiper_pair_buffer #(
  parameter int WIDTH = 7,
  parameter int DEPTH = 2
) (
  input wire logic i_clk, // System clock
  input wire logic i_resetn, // Async reset, active low
  input wire logic i_in_valid, // Word offered
  output logic o_in_ready, // Space for a word
  input wire logic [WIDTH-1:0] i_in_data, // Word in
  output logic o_out_valid, // Word waiting
  input wire logic i_out_ready, // Drain accepts
  output logic [WIDTH-1:0] o_out_data // Oldest word
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic [PTR_W-1:0] next_wr_ptr;
  logic [PTR_W-1:0] next_rd_ptr;
  logic [CNT_W-1:0] next_count;
  logic push;
  logic pop;

  assign o_in_ready = (count != CNT_W'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb
  begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push)
    begin
      next_wr_ptr = (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop)
    begin
      next_rd_ptr = (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop)
    begin
      next_count = count + 1'b1;
    end
    else if (pop && !push)
    begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage holds no control meaning, so it needs no reset
  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= i_in_data;
    end
  end

endmodule

`default_nettype wire

// ==== core/wiper_i2c_slave.sv ====
// Operation
// - SDA falling with SCL high is start
// - SDA changes only while SCL low
// - Acknowledge valid byte on ninth clock
// - Address mismatch leaves SDA high
// - Answer two fixed addresses, bit0 write
// - General call is never acknowledged
// - Restart collision resets serial module
// - SDA rising with SCL high is stop
// - SCL is never held low
// - Malformed transfer leaves setting unchanged
// - Undefined command releases SDA, ignores bus
// - Data byte committed during its acknowledge
// - Partial byte before stop is dropped
// - Written data MSB is ignored
// - Nonzero command code blocks writes
// - Drive all eight read bits, then release
// - Read byte MSB always zero
// - Nonzero command code blocks reads
// - Seven-bit holding register serves both commands
// - Values above 3Fh give full scale
// - Reset loads mid-scale into both registers
// - Start leaves static, stop returns static
`timescale 1ns/1ps
`default_nettype none

module wiper_i2c_slave (
  input wire logic i_clk, // 200 MHz system clock
  input wire logic i_resetn, // Async reset, active low
  input wire logic i_scl, // Bus clock pin, from master
  input wire logic i_sda, // Bus data pin level
  output logic o_sda, // Data pin drive value
  output logic o_sda_oe, // High while pulling data low
  input wire logic i_wiper_ready, // Wiper stage takes a setting
  output logic [6:0] o_setting, // Holding register contents
  output logic [6:0] o_wiper, // Decoded wiper tap
  output logic o_bus_active, // Serial interface active
  output logic o_ignoring, // Waiting for a fresh start
  output logic o_collision // Pulse on restart collision
);

  logic [1:0] scl_pipe;
  logic [1:0] sda_pipe;
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  wiper_i2c_pkg::slave_state_e state;
  wiper_i2c_pkg::slave_state_e next_state;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic in_ack;
  logic next_in_ack;
  logic sda_oe;
  logic next_sda_oe;
  logic cmd_ok;
  logic next_cmd_ok;
  logic master_nack;
  logic next_master_nack;
  logic active;
  logic next_active;
  logic collision;
  logic next_collision;
  logic [6:0] shr;
  logic [6:0] next_shr;
  logic [6:0] wiper;
  logic [6:0] next_wiper;

  logic [7:0] tx_byte;
  logic [6:0] addr;
  logic addr_match;
  logic push;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [6:0] buf_out_data;

  // Pin inputs cross into the system clock through two flops
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      scl_pipe <= 2'h3;
      sda_pipe <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_pipe <= {scl_pipe[0], i_scl};
      sda_pipe <= {sda_pipe[0], i_sda};
      scl_d <= scl_pipe[1];
      sda_d <= sda_pipe[1];
    end
  end

  assign scl_rise = scl_pipe[1] && !scl_d;
  assign scl_fall = !scl_pipe[1] && scl_d;
  // SDA sampled only on SCL edges; edges during SCL high are framing
  assign start_seen = scl_pipe[1] && scl_d && sda_d && !sda_pipe[1];
  assign stop_seen = scl_pipe[1] && scl_d && !sda_d && sda_pipe[1];

  assign tx_byte = {1'b0, shr};
  assign addr = shift[7:1];
  assign addr_match = (addr == wiper_i2c_pkg::ADDR_OPTION_LOW)
    || (addr == wiper_i2c_pkg::ADDR_OPTION_HIGH);

  always_comb
  begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_in_ack = in_ack;
    next_sda_oe = sda_oe;
    next_cmd_ok = cmd_ok;
    next_master_nack = master_nack;
    next_active = active;
    next_collision = 1'b0;
    next_shr = shr;
    push = 1'b0;
    if (stop_seen)
    begin
      // Ends any command; a byte not yet acknowledged is lost
      next_state = wiper_i2c_pkg::ST_IDLE;
      next_bit_cnt = '0;
      next_in_ack = 1'b0;
      next_sda_oe = 1'b0;
      next_cmd_ok = 1'b0;
      next_active = 1'b0;
    end
    else if (start_seen)
    begin
      // Start or restart always reframes, even out of the ignore state
      next_state = wiper_i2c_pkg::ST_ADDR;
      next_bit_cnt = '0;
      // The start's own SCL fall would otherwise count as a data bit
      next_in_ack = 1'b1;
      next_sda_oe = 1'b0;
      next_active = 1'b1;
    end
    else
    begin
      case (state)
        wiper_i2c_pkg::ST_IDLE,
        wiper_i2c_pkg::ST_IGNORE:
        begin
          next_sda_oe = 1'b0;
        end
        wiper_i2c_pkg::ST_RDONE:
        begin
          // Only a stop or restart may follow the last read byte
          if ((scl_rise && !sda_pipe[1]) || scl_fall)
          begin
            next_state = wiper_i2c_pkg::ST_IDLE;
            next_cmd_ok = 1'b0;
            next_collision = 1'b1;
          end
        end
        wiper_i2c_pkg::ST_RDATA:
        begin
          if (scl_rise && in_ack)
          begin
            next_master_nack = sda_pipe[1];
          end
          if (scl_fall && !in_ack)
          begin
            if (bit_cnt == wiper_i2c_pkg::LAST_BIT)
            begin
              next_in_ack = 1'b1;
              next_sda_oe = 1'b0;
              next_bit_cnt = '0;
            end
            else
            begin
              next_bit_cnt = bit_cnt + 1'b1;
              next_sda_oe = !tx_byte[3'(wiper_i2c_pkg::LAST_BIT - bit_cnt - 1'b1)];
            end
          end
          else if (scl_fall)
          begin
            next_in_ack = 1'b0;
            next_bit_cnt = '0;
            if (master_nack)
            begin
              next_state = wiper_i2c_pkg::ST_RDONE;
              next_sda_oe = 1'b0;
            end
            else
            begin
              next_sda_oe = !tx_byte[7];
            end
          end
        end
        default:
        begin
          if (scl_rise && !in_ack)
          begin
            next_shift = {shift[6:0], sda_pipe[1]};
          end
          if (scl_fall && in_ack)
          begin
            next_in_ack = 1'b0;
            next_sda_oe = 1'b0;
            next_bit_cnt = '0;
            if (state == wiper_i2c_pkg::ST_RDATA)
            begin
              next_sda_oe = !tx_byte[7];
            end
          end
          else if (scl_fall && bit_cnt != wiper_i2c_pkg::LAST_BIT)
          begin
            next_bit_cnt = bit_cnt + 1'b1;
          end
          else if (scl_fall)
          begin
            // Eighth bit done: the ack slot starts now
            next_in_ack = 1'b1;
            next_sda_oe = 1'b0;
            next_state = wiper_i2c_pkg::ST_IGNORE;
            case (state)
              wiper_i2c_pkg::ST_ADDR:
              begin
                // General call never matches either option
                if (addr_match && !shift[0])
                begin
                  next_sda_oe = 1'b1;
                  next_state = wiper_i2c_pkg::ST_CMD;
                  next_cmd_ok = 1'b0;
                end
                else if (addr_match && cmd_ok)
                begin
                  next_sda_oe = 1'b1;
                  next_state = wiper_i2c_pkg::ST_RDATA;
                  next_master_nack = 1'b0;
                end
              end
              wiper_i2c_pkg::ST_CMD:
              begin
                if (shift == wiper_i2c_pkg::CMD_SETTING)
                begin
                  next_sda_oe = 1'b1;
                  next_cmd_ok = 1'b1;
                  next_state = wiper_i2c_pkg::ST_WDATA;
                end
                else
                begin
                  next_cmd_ok = 1'b0;
                end
              end
              wiper_i2c_pkg::ST_WDATA:
              begin
                // A full buffer refuses the byte rather than losing it
                if (buf_in_ready)
                begin
                  next_sda_oe = 1'b1;
                  next_state = wiper_i2c_pkg::ST_WDATA;
                  next_shr = shift[6:0];
                  push = 1'b1;
                end
              end
              default:
              begin
                next_state = wiper_i2c_pkg::ST_IGNORE;
              end
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state <= wiper_i2c_pkg::ST_IDLE;
      bit_cnt <= '0;
      shift <= 8'h00;
      in_ack <= 1'b0;
      sda_oe <= 1'b0;
      cmd_ok <= 1'b0;
      master_nack <= 1'b0;
      active <= 1'b0;
      collision <= 1'b0;
      shr <= wiper_i2c_pkg::SETTING_RESET;
    end
    else
    begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      in_ack <= next_in_ack;
      sda_oe <= next_sda_oe;
      cmd_ok <= next_cmd_ok;
      master_nack <= next_master_nack;
      active <= next_active;
      collision <= next_collision;
      shr <= next_shr;
    end
  end

  wiper_pair_buffer #(
    .WIDTH(wiper_i2c_pkg::SETTING_W),
    .DEPTH(wiper_i2c_pkg::BUF_DEPTH)
  ) u_setting_buf (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_in_valid(push),
    .o_in_ready(buf_in_ready),
    .i_in_data(shift[6:0]),
    .o_out_valid(buf_out_valid),
    .i_out_ready(i_wiper_ready),
    .o_out_data(buf_out_data)
  );

  always_comb
  begin
    next_wiper = wiper;
    if (buf_out_valid && i_wiper_ready)
    begin
      if (buf_out_data > wiper_i2c_pkg::WIPER_LIMIT)
      begin
        next_wiper = wiper_i2c_pkg::WIPER_FULL;
      end
      else
      begin
        next_wiper = buf_out_data;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wiper <= wiper_i2c_pkg::SETTING_RESET;
    end
    else
    begin
      wiper <= next_wiper;
    end
  end

  // Open-drain: only ever pulls low; SCL has no driver at all
  assign o_sda = 1'b0;
  assign o_sda_oe = sda_oe;
  assign o_setting = shr;
  assign o_wiper = wiper;
  assign o_bus_active = active;
  assign o_ignoring = (state == wiper_i2c_pkg::ST_IGNORE);
  assign o_collision = collision;

endmodule

`default_nettype wire

// ==== testbench/wiper_i2c_slave_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module wiper_i2c_slave_checker (
  input wire logic i_clk, // Clock
  input wire logic i_resetn, // Reset
  input wire logic i_scl, // Bus clock
  input wire logic i_sda, // Bus data
  input wire logic o_sda, // Drive value
  input wire logic o_sda_oe, // Pull enable
  input wire logic i_wiper_ready, // Wiper ready
  input wire logic [6:0] o_setting, // Holding
  input wire logic [6:0] o_wiper, // Tap
  input wire logic o_bus_active, // Active
  input wire logic o_ignoring, // Ignoring
  input wire logic o_collision // Collision
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  open_drain_a: assert property (o_sda == 1'h0)
    else $error("data drive value not zero");
  wiper_cap_a: assert property (o_wiper <= 7'h40)
    else $error("wiper beyond full scale");
  wiper_track_a: assert property (
    (!o_bus_active && i_wiper_ready) [*8] |->
    o_wiper == ((o_setting > 7'h3F) ? 7'h40 : o_setting))
    else $error("wiper does not follow setting");
  quiet_hold_a: assert property (!o_bus_active |=> $stable(o_setting))
    else $error("setting changed while bus idle");
  ack_commit_a: assert property ($changed(o_setting) |-> o_sda_oe)
    else $error("setting changed outside acknowledge");
  drive_low_scl_a: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data drive changed with clock high");
  ignore_quiet_a: assert property (o_ignoring |-> !o_sda_oe)
    else $error("data driven while ignoring");
  idle_quiet_a: assert property (!o_bus_active |-> !o_sda_oe)
    else $error("data driven while idle");
  start_seen_a: assert property (i_scl && $fell(i_sda) |-> ##[1:6] o_bus_active)
    else $error("start not seen");
  stop_seen_a: assert property (i_scl && $rose(i_sda) |-> ##[1:6] !o_bus_active)
    else $error("stop not seen");
  coll_pulse_a: assert property (o_collision |=> !o_collision)
    else $error("collision pulse too long");
  cover property (o_collision);
  cover property ($changed(o_setting));
  cover property ($rose(o_ignoring));
endmodule
`default_nettype wire

// ==== testbench/i2c_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  input wire logic i_sda, // Resolved data line
  output logic o_scl, // Bus clock
  output logic o_sda // Data drive, 1 releases
);
  logic [7:0] rx;
  logic ack;
  event got;
  initial
  begin
    o_scl = 1'h1;
    o_sda = 1'h1;
  end
  // Clock stands high between frames; a quarter period is 16 ns
  task automatic bit_io(input logic b, output logic r);
    o_sda <= b;
    #16 o_scl <= 1'h1;
    #16 r = i_sda;
    #16 o_scl <= 1'h0;
    #16;
  endtask
  task automatic start_cond();
    o_sda <= 1'h1;
    #16 o_scl <= 1'h1;
    #16 o_sda <= 1'h0;
    #16 o_scl <= 1'h0;
    #16;
  endtask
  task automatic stop_cond();
    o_sda <= 1'h0;
    #16 o_scl <= 1'h1;
    #16 o_sda <= 1'h1;
    #16;
  endtask
  task automatic xbyte(input logic [7:0] tx, input logic a);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(a, ack);
    -> got;
  endtask
endmodule
`default_nettype wire

// ==== testbench/i2c_slave_wiper_command_port_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_wiper_command_port_tb;
  logic i_clk, i_resetn, wready;
  int n_coll = 0;
  wire logic scl, sda_m, sda_bus;
  logic o_sda, oe, active, ignoring, collision;
  logic [6:0] setting, wiper, held;
  logic [8:0] expq[$];
  int miscompares, n_tests;
  // Pull-up: the line is low only when some party pulls it
  assign sda_bus = sda_m & (o_sda | ~oe);
  i2c_master_model i_master (.i_sda(sda_bus), .o_scl(scl), .o_sda(sda_m));
  wiper_i2c_slave i_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_scl(scl), .i_sda(sda_bus),
    .o_sda(o_sda), .o_sda_oe(oe), .i_wiper_ready(wready), .o_setting(setting),
    .o_wiper(wiper), .o_bus_active(active), .o_ignoring(ignoring), .o_collision(collision));
  initial
  begin
    i_clk = 1'h0;
    forever #2.5 i_clk = ~i_clk;
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d, miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(i_master.got) chk({i_master.rx, i_master.ack}, expq.pop_front());
  always @(posedge i_clk) if (collision === 1'h1) n_coll <= n_coll + 1;
  function automatic logic [6:0] dec(input logic [6:0] v);
    return (v > wiper_i2c_pkg::WIPER_LIMIT) ? wiper_i2c_pkg::WIPER_FULL : v;
  endfunction
  task automatic xw(input logic [7:0] tx, input logic a);
    expq.push_back({tx, a});
    i_master.xbyte(tx, 1'h1);
  endtask
  task automatic xr(input logic a);
    expq.push_back({1'h0, held, a});
    i_master.xbyte(8'hFF, a);
  endtask
  task automatic regs();
    repeat (8) @(posedge i_clk);
    #1;
    chk({2'h0, setting}, {2'h0, held});
    chk({2'h0, wiper}, {2'h0, dec(held)});
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_master.start_cond();
    xw({a, 1'h0}, 1'h0);
    xw(wiper_i2c_pkg::CMD_SETTING, 1'h0);
    xw(d, 1'h0);
    i_master.stop_cond();
    held = d[6:0];
    regs();
  endtask
  task automatic rd(input logic [6:0] a);
    i_master.start_cond();
    xw({a, 1'h0}, 1'h0);
    xw(8'h00, 1'h0);
    i_master.start_cond();
    xw({a, 1'h1}, 1'h0);
    xr(1'h0);
    xr(1'h1);
  endtask
  initial
  begin
    logic r;
    logic [7:0] vals [4];
    int c0;
    miscompares = 0;
    n_tests = 0;
    held = wiper_i2c_pkg::SETTING_RESET;
    i_resetn = 1'h0;
    wready = 1'h1;
    void'($urandom(32'h16A3));
    vals = '{8'hC0, 8'h3F, 8'hFF, 8'($urandom)};
    repeat (10) @(posedge i_clk);
    i_resetn <= 1'h1;
    regs();
    chk({7'h0, oe, active}, 9'h0);
    for (int k = 0; k < 4; k++)
      wr(k[0] ? wiper_i2c_pkg::ADDR_OPTION_HIGH : wiper_i2c_pkg::ADDR_OPTION_LOW, vals[k]);
    rd(wiper_i2c_pkg::ADDR_OPTION_LOW);
    i_master.stop_cond();
    rd(wiper_i2c_pkg::ADDR_OPTION_HIGH);
    // Data low at the clock rise where only a restart or stop may come
    c0 = n_coll;
    i_master.bit_io(1'h0, r);
    chk(9'(n_coll - c0), 9'h1);
    i_master.stop_cond();
    vals = '{8'h00, 8'h5E, 8'h5D, 8'hB8};
    for (int k = 0; k < 4; k++)
    begin
      i_master.start_cond();
      xw(vals[k], 1'h1);
      xw(8'h40, 1'h1);
      chk({8'h0, ignoring}, 9'h1);
      i_master.stop_cond();
      regs();
    end
    i_master.start_cond();
    xw(8'h5C, 1'h0);
    xw(8'($urandom_range(255, 1)), 1'h1);
    xw(8'h11, 1'h1);
    i_master.start_cond();
    xw(8'h5D, 1'h1);
    i_master.stop_cond();
    regs();
    i_master.start_cond();
    xw(8'h7C, 1'h0);
    xw(8'h00, 1'h0);
    repeat (4) i_master.bit_io(1'h0, r);
    i_master.stop_cond();
    regs();
    // Stalled wiper stage: two words fit, the third is refused
    @(posedge i_clk);
    wready <= 1'h0;
    i_master.start_cond();
    xw(8'h5C, 1'h0);
    xw(8'h00, 1'h0);
    xw(8'h15, 1'h0);
    xw(8'h2A, 1'h0);
    xw(8'h33, 1'h1);
    i_master.stop_cond();
    chk({2'h0, wiper}, {2'h0, dec(held)});
    held = 7'h2A;
    @(posedge i_clk);
    wready <= 1'h1;
    regs();
    complete_run();
  end
  initial
  begin
    #300000;
    miscompares++;
    complete_run();
  end
endmodule
bind wiper_i2c_slave wiper_i2c_slave_checker i_chk (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
  .i_wiper_ready(i_wiper_ready), .o_setting(o_setting), .o_wiper(o_wiper),
  .o_bus_active(o_bus_active), .o_ignoring(o_ignoring), .o_collision(o_collision));
`default_nettype wire
